// File: core/pcs_strobe_gen.sv
/*
 Range-gate strobe generator: measures an incoming pulse, delays it by
 sixteen slow periods and places a 500 ns strobe at the centre of the
 delayed copy.
 Assumes a 250 MHz reference clock, an asynchronous active-low reset
 and an input pulse asynchronous to the reference clock.
*/
// Notes on behaviour
// RL1 - One fixed-width strobe per pulse, centred
// RL2 - Pulses of one to sixteen microseconds
// RL3 - Base clock gives slow and fast quadrature
// RL4 - Sixteen-stage slow delay line for pulse
// RL5 - Thirty-two-stage fast register carries marker
// RL6 - Resynchronised input raises counter run enable
// RL7 - Count per slow edge; stop after fall
// RL8 - Frozen count decoded one-hot into sixteen
// RL9 - End of pulse triggers one-shot
// RL10 - One-shot selects load on fast fall
// RL11 - Marker leaves serially for one period
// RL12 - One-shot clears counter to zero
// RL13 - Serial mode select held permanently high
// RL14 - Four-bit counter saturates, never wraps
`timescale 1ns/1ps
`default_nettype none
`include "pcs_map.svh"

module pcs_strobe_gen (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Incoming radar pulse, asynchronous
    input wire logic pulse_in,
    // Strobe and delayed pulse
    output logic strobe_out,
    output logic delayed_pulse_out,
    // Observation
    output logic counter_run_enable_out,
    output logic [`PCS_CNT_W-1:0] center_count_out,
    output logic slow_clk_out,
    output logic fast_clk_out
);

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [`PCS_LONG_HALF-1:0] pcs_decode16(
        input logic [`PCS_CNT_W-1:0] value
    );
        logic [`PCS_LONG_HALF-1:0] lines;
        lines = '0;
        lines[value] = 1'b1;
        return lines;
    endfunction

    // ****************************************
    // Clock derivation
    // ****************************************
    pcs_pkg::pcs_clk_t clocks;

    pcs_clkgen u_clkgen (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .clocks_out(clocks)
    );

    // ****************************************
    // Input synchroniser
    // ****************************************
    // Two flops before any logic; the first feeds only the second.
    logic in_meta;
    logic in_sync;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            in_meta <= 1'b0;
            in_sync <= 1'b0;
        end else begin
            in_meta <= pulse_in;
            in_sync <= in_meta;
        end
    end

    // ****************************************
    // Measurement counter
    // ****************************************
    logic counter_run_enable;
    logic next_counter_run_enable;
    logic [`PCS_CNT_W-1:0] count;
    logic [`PCS_CNT_W-1:0] next_count;
    logic end_of_pulse;
    logic counter_clear;

    always_comb begin
        next_counter_run_enable = counter_run_enable;
        next_count = count;
        end_of_pulse = 1'b0;
        if (clocks.slow_rise) begin
            // Resample on the slow clock, as the measurement D flop does
            next_counter_run_enable = in_sync; // RL6 RL7
            end_of_pulse = counter_run_enable && !in_sync; // RL9
            // Saturate: longer pulses than the range stay at the top
            if (counter_run_enable && (count != `PCS_CNT_MAX)) begin
                next_count = count + `PCS_CNT_W'(1); // RL7 RL14 RL2
            end
        end
        if (counter_clear) begin
            next_count = '0; // RL12
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            counter_run_enable <= 1'b0;
            count <= '0;
        end else begin
            counter_run_enable <= next_counter_run_enable;
            count <= next_count;
        end
    end

    // ****************************************
    // One-shot
    // ****************************************
    // Lasts exactly one fast period, rising edge to rising edge, so it
    // always spans one fast falling edge for the load.
    pcs_pkg::pcs_os_state_t os_state;
    pcs_pkg::pcs_os_state_t next_os_state;
    logic load_select;

    always_comb begin
        next_os_state = os_state;
        counter_clear = 1'b0;
        load_select = (os_state == pcs_pkg::PCS_OS_FIRE); // RL10
        unique case (os_state)
            pcs_pkg::PCS_OS_IDLE: begin
                if (end_of_pulse) begin
                    next_os_state = pcs_pkg::PCS_OS_ARMED; // RL9
                end
            end
            pcs_pkg::PCS_OS_ARMED: begin
                if (clocks.fast_rise) begin
                    next_os_state = pcs_pkg::PCS_OS_FIRE; // RL9
                end
            end
            pcs_pkg::PCS_OS_FIRE: begin
                if (clocks.fast_rise) begin
                    next_os_state = pcs_pkg::PCS_OS_IDLE;
                    counter_clear = 1'b1; // RL12
                end
            end
            default: begin
                next_os_state = pcs_pkg::PCS_OS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            os_state <= pcs_pkg::PCS_OS_IDLE;
        end else begin
            os_state <= next_os_state;
        end
    end

    // ****************************************
    // Slow delay line
    // ****************************************
    logic [`PCS_DLY_LEN-1:0] delay_line;
    logic [`PCS_DLY_LEN-1:0] next_delay_line;

    always_comb begin
        next_delay_line = delay_line;
        // Fed from the slow resample, so the copy trails by sixteen full
        // periods and the marker lands on its middle
        if (clocks.slow_rise) begin
            next_delay_line = {delay_line[`PCS_DLY_LEN-2:0], counter_run_enable}; // RL4
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            delay_line <= '0;
        end else begin
            delay_line <= next_delay_line;
        end
    end

    // ****************************************
    // Long marker register
    // ****************************************
    // Stage k is loaded with decoded line k and needs 31-k fast periods
    // to reach the output, which lands it mid-way along the delayed copy.
    logic serial_mode_select;
    logic [`PCS_LONG_LEN-1:0] marker;
    logic [`PCS_LONG_LEN-1:0] next_marker;
    logic [`PCS_LONG_HALF-1:0] decoded_center;

    assign serial_mode_select = 1'b1; // RL13

    always_comb begin
        decoded_center = pcs_decode16(count); // RL8
        next_marker = marker;
        if (load_select && clocks.fast_fall) begin
            // Parallel load into the first half only
            next_marker = {marker[`PCS_LONG_LEN-1:`PCS_LONG_HALF],
                decoded_center}; // RL8 RL10
        end else if (serial_mode_select && clocks.fast_rise) begin
            next_marker = {marker[`PCS_LONG_LEN-2:0], 1'b0}; // RL5 RL11
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            marker <= '0;
        end else begin
            marker <= next_marker;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // All outputs come straight from flops, so no decode glitches
    // reach the range gate.
    always_comb begin
        strobe_out = marker[`PCS_LONG_LAST]; // RL1 RL11
        delayed_pulse_out = delay_line[`PCS_DLY_LAST]; // RL4
        counter_run_enable_out = counter_run_enable;
        center_count_out = count;
        slow_clk_out = clocks.slow_level;
        fast_clk_out = clocks.fast_level;
    end

endmodule
`default_nettype wire

// File: core/pcs_map.svh
/*
 Named constants for the range-gate strobe generator: clock periods,
 derived cycle counts and register lengths.
 Assumes a 250 MHz reference clock; included by the package users.
*/
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// ****************************************
// Times in nanoseconds, as specified
// ****************************************
`define PCS_REF_PERIOD_NS 4
`define PCS_BASE_PERIOD_NS 100
`define PCS_SLOW_PERIOD_NS 1000
`define PCS_FAST_PERIOD_NS 500

// ****************************************
// Derived counts
// ****************************************
`define PCS_BASE_CYCLES (`PCS_BASE_PERIOD_NS / `PCS_REF_PERIOD_NS)
`define PCS_SLOW_TICKS (`PCS_SLOW_PERIOD_NS / `PCS_BASE_PERIOD_NS)
`define PCS_SLOW_HALF_TICKS (`PCS_SLOW_TICKS / 2)
`define PCS_QUAD_NS (`PCS_FAST_PERIOD_NS / 2)
`define PCS_QUAD_TICKS (`PCS_QUAD_NS / `PCS_BASE_PERIOD_NS)
`define PCS_QUAD_SUB ((`PCS_QUAD_NS % `PCS_BASE_PERIOD_NS) / `PCS_REF_PERIOD_NS)

// ****************************************
// Widths and lengths
// ****************************************
`define PCS_SUB_W 5
`define PCS_TICK_W 4
`define PCS_CNT_W 4
`define PCS_CNT_MAX 4'hf
`define PCS_DLY_LEN 16
`define PCS_DLY_LAST 15
`define PCS_LONG_LEN 32
`define PCS_LONG_HALF 16
`define PCS_LONG_LAST 31

`endif

// File: core/pcs_pkg.sv
/*
 Types shared by the strobe generator and its clock divider.
 Needs nothing from pcs_map.svh; every width here is fixed.
*/
package pcs_pkg;

    // Derived clock levels and edge pulses, all on the reference clock
    typedef struct packed {
        logic slow_level;
        logic fast_level;
        logic base_tick;
        logic slow_rise;
        logic fast_rise;
        logic fast_fall;
    } pcs_clk_t;

    // One-shot sequencer
    typedef enum logic [2:0] {
        PCS_OS_IDLE = 3'b001,
        PCS_OS_ARMED = 3'b010,
        PCS_OS_FIRE = 3'b100
    } pcs_os_state_t;

endpackage

// File: core/pcs_clkgen.sv
/*
 Derives the 10 MHz base tick, the 1 MHz measurement clock and the
 2 MHz shift clock as edge pulses on the 250 MHz reference clock.
 Assumes one reference clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcs_map.svh"

module pcs_clkgen (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Derived clocks
    output var pcs_pkg::pcs_clk_t clocks_out
);

    logic [`PCS_SUB_W-1:0] sub;
    logic [`PCS_SUB_W-1:0] next_sub;
    logic [`PCS_TICK_W-1:0] tick;
    logic [`PCS_TICK_W-1:0] next_tick;
    pcs_pkg::pcs_clk_t next_clocks;
    logic base_end;
    logic at_zero;
    logic at_quad;

    // ****************************************
    // Base divider and edge placement
    // ****************************************
    // Slow edges sit on base ticks, fast rises half a fast period later:
    // the two clocks never share a rising edge (quadrature).
    always_comb begin
        base_end = (sub == `PCS_SUB_W'(`PCS_BASE_CYCLES - 1));
        next_sub = base_end ? '0 : sub + `PCS_SUB_W'(1);
        next_tick = tick;
        if (base_end) begin
            next_tick = (tick == `PCS_TICK_W'(`PCS_SLOW_TICKS - 1)) ? '0
                : tick + `PCS_TICK_W'(1);
        end
        at_zero = (sub == '0);
        at_quad = (sub == `PCS_SUB_W'(`PCS_QUAD_SUB));
        next_clocks.base_tick = at_zero; // RL3
        next_clocks.slow_rise = at_zero && (tick == '0);
        next_clocks.fast_fall = at_zero && ((tick == '0)
            || (tick == `PCS_TICK_W'(`PCS_SLOW_HALF_TICKS)));
        next_clocks.fast_rise = at_quad && ((tick == `PCS_TICK_W'(`PCS_QUAD_TICKS))
            || (tick == `PCS_TICK_W'(`PCS_QUAD_TICKS + `PCS_SLOW_HALF_TICKS)));
        next_clocks.slow_level = (tick < `PCS_TICK_W'(`PCS_SLOW_HALF_TICKS));
        next_clocks.fast_level = next_clocks.fast_rise ? 1'b1
            : (next_clocks.fast_fall ? 1'b0 : clocks_out.fast_level);
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sub <= '0;
            tick <= '0;
            clocks_out <= '0;
        end else begin
            sub <= next_sub;
            tick <= next_tick;
            clocks_out <= next_clocks;
        end
    end

endmodule
`default_nettype wire

// File: bench/pcs_strobe_gen_monitor.sv
/* Port checker for the strobe generator.
 Assumes one reference clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
`include "pcs_map.svh"
module pcs_strobe_gen_monitor (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Watched outputs
    input wire logic strobe_out,
    input wire logic delayed_pulse_out,
    input wire logic counter_run_enable_out,
    input wire logic [`PCS_CNT_W-1:0] center_count_out,
    input wire logic slow_clk_out,
    input wire logic fast_clk_out
);
    // ****
    // Strobe length counter
    // ****
    logic [7:0] hi_cnt;
    logic [7:0] next_hi_cnt;
    always_comb begin
        next_hi_cnt = strobe_out ? hi_cnt + 8'h01 : 8'h00;
    end
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hi_cnt <= 8'h00;
        end else begin
            hi_cnt <= next_hi_cnt;
        end
    end
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    strobe_width_a: assert property ($fell(strobe_out) |-> hi_cnt == 8'h7d)
        else $error("strobe width wrong");
    strobe_bound_a: assert property (strobe_out |-> hi_cnt < 8'h7d)
        else $error("strobe too long");
    slow_period_a: assert property ($rose(slow_clk_out) |-> ##250 $rose(slow_clk_out))
        else $error("slow clock period wrong");
    fast_quad_a: assert property ($rose(slow_clk_out) |-> ##[62:63] $rose(fast_clk_out))
        else $error("shift clock not in quadrature");
    fast_period_a: assert property ($rose(fast_clk_out) |-> ##[124:126] $rose(fast_clk_out))
        else $error("shift clock period wrong");
    enable_edge_a: assert property ($changed(counter_run_enable_out)
        |-> slow_clk_out && !$past(slow_clk_out, 3))
        else $error("run enable off slow edge");
    count_step_a: assert property ($changed(center_count_out)
        && center_count_out != 4'h0
        |-> center_count_out == $past(center_count_out) + 4'h1)
        else $error("count did not step by one");
    count_clear_a: assert property ($changed(center_count_out)
        && center_count_out == 4'h0
        |-> !counter_run_enable_out)
        else $error("count cleared while running");
    delay_edge_a: assert property ($changed(delayed_pulse_out)
        |-> slow_clk_out && !$past(slow_clk_out, 3))
        else $error("delayed pulse off slow edge");
    strobe_edge_a: assert property ($rose(strobe_out)
        |-> fast_clk_out && !$past(fast_clk_out, 3) && !counter_run_enable_out)
        else $error("strobe off shift edge");
endmodule
bind pcs_strobe_gen pcs_strobe_gen_monitor mon (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .strobe_out(strobe_out),
    .delayed_pulse_out(delayed_pulse_out), .counter_run_enable_out(counter_run_enable_out),
    .center_count_out(center_count_out), .slow_clk_out(slow_clk_out),
    .fast_clk_out(fast_clk_out)
);
`default_nettype wire

// File: bench/pcs_radar_source.sv
/* Radar receiver model: one active-high pulse of a requested length.
 Assumes requests come one at a time, each a single-cycle fire. */
`timescale 1ns/1ps
`default_nettype none
module pcs_radar_source (
    // Clock and request
    input wire logic ref_clk_in,
    input wire logic fire_in,
    input wire logic [4:0] width_us_in,
    // Pulse to the block
    output logic pulse_out
);
    // ****
    // Pulse timer, 250 reference cycles per microsecond
    // ****
    int unsigned remain = 0;
    initial pulse_out = 1'b0;
    always @(posedge ref_clk_in) begin
        if (fire_in) begin
            remain <= 250 * width_us_in;
            pulse_out <= 1'b1;
        end else if (remain > 1) begin
            remain <= remain - 1;
        end else begin
            remain <= 0;
            pulse_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: bench/pcs_strobe_gen_test.sv
/* Self-checking bench for the strobe generator.
 Assumes design files and the radar model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "pcs_map.svh"
module pcs_strobe_gen_test;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic fire = 1'b0;
    logic [4:0] width_us = 5'h01;
    logic pulse, strobe, dly, run_en, slow_clk, fast_clk;
    logic [`PCS_CNT_W-1:0] count;
    logic [3:0] peak;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t_in, t_r, t_f, t_s, n_strobe;
    // ****
    // Clock, model and design
    // ****
    initial forever #2 ref_clk_in = ~ref_clk_in;
    pcs_radar_source src (.ref_clk_in(ref_clk_in), .fire_in(fire), .width_us_in(width_us),
        .pulse_out(pulse));
    pcs_strobe_gen uut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .pulse_in(pulse),
        .strobe_out(strobe), .delayed_pulse_out(dly), .counter_run_enable_out(run_en),
        .center_count_out(count), .slow_clk_out(slow_clk), .fast_clk_out(fast_clk));
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if ($rose(dly)) t_r <= cyc;
        if ($fell(dly)) t_f <= cyc;
        if ($rose(strobe)) n_strobe <= n_strobe + 1;
        if ($rose(strobe)) t_s <= cyc;
        if (count > peak) peak <= count;
    end
    function automatic logic [31:0] near(input int a, input int b, input int tol);
        return {31'h0, (a - b <= tol) && (b - a <= tol)};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_errors++;
            $display("Error at %0t: saw %0h expected %0h", $time, seen, want);
        end
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Waits out the delay line; the 300-cycle margin keeps the next pulse 1.2 us clear of the delayed fall
    task automatic run_pulse(input int w);
        int n;
        t_r = -1;
        t_f = -1;
        n_strobe = 0;
        peak = 4'h0;
        @(posedge ref_clk_in);
        width_us <= w[4:0];
        fire <= 1'b1;
        t_in = cyc;
        @(posedge ref_clk_in);
        fire <= 1'b0;
        for (n = 0; n < 12000 && t_f < 0; n++) @(posedge ref_clk_in);
        if (t_f < 0) begin
            n_errors++;
            $display("Error at %0t: no delayed pulse", $time);
            print_verdict();
        end
        repeat (300) @(posedge ref_clk_in);
        check(n_strobe, 32'h1);
        check(near(t_r - t_in, 4130, 140), 32'h1);
        check(near(t_f - t_r, w * 250, 10), 32'h1);
        check(near(peak, (w > 15) ? 15 : w, 0), 32'h1);
        check(near(t_s + 62, (t_r + t_f) / 2, 130), 32'h1);
        check({28'h0, count}, 32'h0);
    endtask
    task automatic test_reset_state();
        check({25'h0, count, strobe, dly, run_en}, 32'h0);
    endtask
    task automatic test_widths();
        run_pulse(1);
        run_pulse(7);
        run_pulse(16);
    endtask
    task automatic test_reset_recovery();
        @(posedge ref_clk_in);
        width_us <= 5'h05;
        fire <= 1'b1;
        @(posedge ref_clk_in);
        fire <= 1'b0;
        repeat (800) @(posedge ref_clk_in);
        reset_n_in <= 1'b0;
        repeat (16) @(posedge ref_clk_in);
        check({25'h0, count, strobe, dly, run_en}, 32'h0);
        reset_n_in <= 1'b1;
        repeat (5000) @(posedge ref_clk_in);
        run_pulse(3);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk_in);
        test_reset_state();
        reset_n_in <= 1'b1;
        test_widths();
        test_reset_recovery();
        print_verdict();
    end
endmodule
`default_nettype wire
